// file: hw/csf_pkg.sv
// package for the cpu status flag register block
package csf_pkg;

   // ************************************************************
   // register offsets on the plain register port
   // ************************************************************
   localparam logic [1:0] CSF_ADDR_STATUS = 2'h0;
   localparam logic [1:0] CSF_ADDR_CORE = 2'h1;
   localparam logic [1:0] CSF_ADDR_IRQCTL = 2'h2;

   // ************************************************************
   // status, core control and irq control register bit positions
   // ************************************************************
   localparam int CSF_BIT_ACC_A_OVF = 15;
   localparam int CSF_BIT_ACC_B_OVF = 14;
   localparam int CSF_BIT_ACC_A_CLAMP = 13;
   localparam int CSF_BIT_ACC_B_CLAMP = 12;
   localparam int CSF_BIT_EITHER_OVF = 11;
   localparam int CSF_BIT_EITHER_CLAMP = 10;
   localparam int CSF_BIT_LOOP = 9;
   localparam int CSF_BIT_NIB = 8;
   localparam int CSF_BIT_PRIO_HI = 7;
   localparam int CSF_BIT_PRIO_LO = 5;
   localparam int CSF_BIT_REP = 4;
   localparam int CSF_BIT_NEG = 3;
   localparam int CSF_BIT_OVF = 2;
   localparam int CSF_BIT_ZERO = 1;
   localparam int CSF_BIT_CARRY = 0;
   localparam int CSF_BIT_TOP = 3;
   localparam int CSF_BIT_NEST = 15;

   // ************************************************************
   // reset values and constants
   // ************************************************************
   localparam logic [15:0] CSF_STATUS_RST = 16'h0000;
   localparam logic [2:0] CSF_PRIO_RST = 3'h0;
   localparam logic [2:0] CSF_PRIO_MAX = 3'h7;

   // ************************************************************
   // alu result flags from the execution units
   // ************************************************************
   typedef struct packed {
      logic upd_n;
      logic n;
      logic upd_ov;
      logic ov;
      logic upd_z;
      logic z;
      logic upd_c;
      logic c;
      logic upd_nib;
      logic nib;
   } csf_alu_t;

   // accumulator events from the dsp unit
   typedef struct packed {
      logic ovf_a;
      logic ovf_b;
      logic sat_a;
      logic sat_b;
   } csf_acc_t;

endpackage

// file: hw/csf_prio.sv
// priority forming and user interrupt mask
`timescale 1ns/1ps
`default_nettype none
module csf_prio
(
   input wire logic [2:0] prio_low, // status priority field
   input wire logic top_bit, // core control top bit
   output logic [3:0] prio_level, // four-bit cpu priority
   output logic user_irq_block // user interrupts masked
);
   import csf_pkg::*;
   assign prio_level = {top_bit, prio_low}; // see RULE2
   assign user_irq_block = top_bit | (prio_low == CSF_PRIO_MAX); // see RULE3 see RULE4
endmodule
`default_nettype wire

// file: hw/csf_top.sv
// cpu status flag register with core and interrupt control bits
//
// Contract
// RULE1: bits 7 to 5 hold the low three priority bits and software may write them.
// RULE2: the cpu priority is the core-control top bit above the three status bits.
// RULE3: user interrupts are blocked whenever the top bit is one.
// RULE4: field value 111 means level 7 or 15 and blocks all user interrupts.
// RULE5: software writes to the priority bits are ignored while nesting_off is set.
// RULE6: software may read and clear the sticky clamp flags but never set them.
// RULE7: clearing the combined sticky flag in bit 10 clears both single sticky flags.
// RULE8: bit 4 is one while a repeat loop runs, else zero, and is read-only.
// RULE9: bit 3 is set on a negative alu result and cleared otherwise.
// RULE10: bit 2 is set on signed overflow and cleared otherwise.
// RULE11: bit 1 stays set once set and clears only on a non-zero result; the code also loads bit 1 from a software status write.
// RULE12: bit 0 is set on carry out of the msb and cleared otherwise.
// RULE13: the core-control top bit is read-only to software.
// RULE14: irq control register 1 holds the nesting_off control bit.
// RULE15: bits 15 and 14 show accumulator overflow and bit 11 their or, read-only.
// RULE16: bit 9 shows an active hardware loop and bit 8 is the nibble carry.
`timescale 1ns/1ps
`default_nettype none
module csf_top
(
   input wire logic mclk, // core clock, 25 MHz
   input wire logic reset, // synchronous reset, active high
   input wire logic [1:0] reg_addr, // register address
   input wire logic [15:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [15:0] reg_rdata, // read data, cycle after strobe
   input wire csf_pkg::csf_alu_t alu_flags, // alu flag updates
   input wire csf_pkg::csf_acc_t acc_events, // accumulator events
   input wire logic repeat_active, // single-instruction repeat running
   input wire logic hw_loop_active, // hardware loop running
   input wire logic prio_top_set, // core raises top bit (trap entry)
   input wire logic prio_top_clr, // core drops top bit (trap exit)
   input wire logic prio_load, // core loads new priority field
   input wire logic [2:0] prio_load_val, // value for the core load
   output logic [15:0] cpu_status_reg, // status register contents
   output logic [3:0] cpu_prio, // four-bit cpu priority
   output logic user_irq_block // user interrupts masked
);
   import csf_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   logic acc_a_overflow_q;
   logic acc_b_overflow_q;
   logic acc_a_sticky_clamp_q;
   logic acc_b_sticky_clamp_q;
   logic nibble_carry_q;
   logic [2:0] cpu_prio_level_q;
   logic neg_q;
   logic ovf_q;
   logic zero_q;
   logic carry_q;
   logic cpu_prio_top_bit_q;
   logic nesting_off_q;
   logic [15:0] rdata_q;

   // ************************************************************
   // decode
   // ************************************************************
   wire wr_status = reg_wr && (reg_addr == CSF_ADDR_STATUS);
   wire wr_irqctl = reg_wr && (reg_addr == CSF_ADDR_IRQCTL);
   wire either_acc_overflow = acc_a_overflow_q | acc_b_overflow_q; // see RULE15
   wire either_acc_sticky_clamp = acc_a_sticky_clamp_q | acc_b_sticky_clamp_q;
   // software clears only: a zero written clears, a one is ignored
   wire clamp_both_clr = wr_status && !reg_wdata[CSF_BIT_EITHER_CLAMP]; // see RULE7
   wire clamp_a_clr = wr_status && (!reg_wdata[CSF_BIT_ACC_A_CLAMP] || clamp_both_clr); // see RULE6
   wire clamp_b_clr = wr_status && (!reg_wdata[CSF_BIT_ACC_B_CLAMP] || clamp_both_clr); // see RULE6
   wire prio_sw_wr = wr_status && !nesting_off_q; // see RULE5

   // ************************************************************
   // accumulator flags
   // ************************************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         acc_a_overflow_q <= 1'b0;
         acc_b_overflow_q <= 1'b0;
         acc_a_sticky_clamp_q <= 1'b0;
         acc_b_sticky_clamp_q <= 1'b0;
      end
      else
      begin
         acc_a_overflow_q <= acc_events.ovf_a; // see RULE15
         acc_b_overflow_q <= acc_events.ovf_b; // see RULE15
         // set wins over a clear in the same cycle
         if (acc_events.sat_a)
            acc_a_sticky_clamp_q <= 1'b1;
         else if (clamp_a_clr)
            acc_a_sticky_clamp_q <= 1'b0; // see RULE6
         if (acc_events.sat_b)
            acc_b_sticky_clamp_q <= 1'b1;
         else if (clamp_b_clr)
            acc_b_sticky_clamp_q <= 1'b0; // see RULE6
      end
   end

   // ************************************************************
   // alu flags, hardware update wins over software write
   // ************************************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         neg_q <= 1'b0;
         ovf_q <= 1'b0;
         zero_q <= 1'b0;
         carry_q <= 1'b0;
         nibble_carry_q <= 1'b0;
      end
      else
      begin
         if (alu_flags.upd_n)
            neg_q <= alu_flags.n; // see RULE9
         else if (wr_status)
            neg_q <= reg_wdata[CSF_BIT_NEG];
         if (alu_flags.upd_ov)
            ovf_q <= alu_flags.ov; // see RULE10
         else if (wr_status)
            ovf_q <= reg_wdata[CSF_BIT_OVF];
         // zero clears only on a non-zero result or a software status write
         if (alu_flags.upd_z && alu_flags.z)
            zero_q <= 1'b1; // see RULE11
         else if (alu_flags.upd_z)
            zero_q <= 1'b0; // see RULE11
         else if (wr_status)
            zero_q <= reg_wdata[CSF_BIT_ZERO];
         if (alu_flags.upd_c)
            carry_q <= alu_flags.c; // see RULE12
         else if (wr_status)
            carry_q <= reg_wdata[CSF_BIT_CARRY];
         if (alu_flags.upd_nib)
            nibble_carry_q <= alu_flags.nib; // see RULE16
         else if (wr_status)
            nibble_carry_q <= reg_wdata[CSF_BIT_NIB];
      end
   end

   // ************************************************************
   // priority field and control bits
   // ************************************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         cpu_prio_level_q <= CSF_PRIO_RST;
         cpu_prio_top_bit_q <= 1'b0;
         nesting_off_q <= 1'b0;
      end
      else
      begin
         // core load outranks software
         if (prio_load)
            cpu_prio_level_q <= prio_load_val;
         else if (prio_sw_wr)
            cpu_prio_level_q <= reg_wdata[CSF_BIT_PRIO_HI:CSF_BIT_PRIO_LO]; // see RULE1
         // top bit moves only by the core
         if (prio_top_set)
            cpu_prio_top_bit_q <= 1'b1; // see RULE13
         else if (prio_top_clr)
            cpu_prio_top_bit_q <= 1'b0; // see RULE13
         if (wr_irqctl)
            nesting_off_q <= reg_wdata[CSF_BIT_NEST]; // see RULE14
      end
   end

   // ************************************************************
   // status image and read port
   // ************************************************************
   assign cpu_status_reg = {acc_a_overflow_q, acc_b_overflow_q, acc_a_sticky_clamp_q,
      acc_b_sticky_clamp_q, either_acc_overflow, either_acc_sticky_clamp,
      hw_loop_active, nibble_carry_q, cpu_prio_level_q, repeat_active, // see RULE8 see RULE16
      neg_q, ovf_q, zero_q, carry_q};

   wire [15:0] core_image = {12'h000, cpu_prio_top_bit_q, 3'h0};
   wire [15:0] irqctl_image = {nesting_off_q, 15'h0000};
   wire [15:0] rd_mux = (reg_addr == CSF_ADDR_STATUS) ? cpu_status_reg :
                        (reg_addr == CSF_ADDR_CORE) ? core_image :
                        (reg_addr == CSF_ADDR_IRQCTL) ? irqctl_image : 16'h0000;

   always_ff @(posedge mclk)
   begin
      if (reset)
         rdata_q <= CSF_STATUS_RST;
      else if (reg_rd)
         rdata_q <= rd_mux;
      else
         rdata_q <= 16'h0000;
   end
   assign reg_rdata = rdata_q;

   // ************************************************************
   // priority and mask
   // ************************************************************
   csf_prio u_prio
   (
      .prio_low(cpu_prio_level_q),
      .top_bit(cpu_prio_top_bit_q),
      .prio_level(cpu_prio),
      .user_irq_block(user_irq_block)
   );

endmodule
`default_nettype wire

// file: tb/csf_core_model.sv
// far-side core model issuing flag updates and priority events
`timescale 1ns/1ps
`default_nettype none
module csf_core_model
(
   input wire logic mclk, // core clock
   input wire csf_pkg::csf_alu_t alu_req, // alu update to issue
   input wire csf_pkg::csf_acc_t acc_req, // dsp event to issue
   input wire logic [2:0] ctl_req, // top set, top clear, load
   input wire logic [4:0] lvl_req, // repeat, loop, load value
   output var csf_pkg::csf_alu_t alu_flags, // alu flag updates
   output var csf_pkg::csf_acc_t acc_events, // accumulator events
   output var logic prio_top_set, // top bit set pulse
   output var logic prio_top_clr, // top bit clear pulse
   output var logic prio_load, // priority load pulse
   output var logic repeat_active, // repeat loop level
   output var logic hw_loop_active, // hardware loop level
   output var logic [2:0] prio_load_val // priority load value
);
   import csf_pkg::*;
   // ******************************
   // one stage, as after decode
   // ******************************
   always_ff @(posedge mclk)
   begin
      alu_flags <= alu_req;
      acc_events <= acc_req;
      {prio_top_set, prio_top_clr, prio_load} <= ctl_req;
      {repeat_active, hw_loop_active, prio_load_val} <= lvl_req;
   end
endmodule
`default_nettype wire

// file: tb/csf_top_asserts.sv
// port assertions for the status flag register
`timescale 1ns/1ps
`default_nettype none
module csf_top_asserts
(
   input wire logic mclk, // core clock
   input wire logic reset, // sync reset
   input wire logic [1:0] reg_addr, // register address
   input wire logic [15:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire csf_pkg::csf_alu_t alu_flags, // alu updates
   input wire csf_pkg::csf_acc_t acc_events, // dsp events
   input wire logic repeat_active, // repeat level
   input wire logic hw_loop_active, // loop level
   input wire logic prio_top_set, // top set
   input wire logic prio_top_clr, // top clear
   input wire logic [15:0] cpu_status_reg, // status image
   input wire logic [3:0] cpu_prio, // cpu priority
   input wire logic user_irq_block // user mask
);
   import csf_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   wire logic sw_st = reg_wr && reg_addr == CSF_ADDR_STATUS;
   sequence zero_set;
      alu_flags.upd_z && alu_flags.z;
   endsequence
   sequence zero_quiet;
      (!alu_flags.upd_z && !sw_st) [*2];
   endsequence
   // ******************************
   // checks
   // ******************************
   a_prio_field: assert property (cpu_prio[2:0] == cpu_status_reg[7:5])
      else $error("priority field mismatch");
   a_top_mask: assert property (cpu_prio[3] |-> user_irq_block)
      else $error("top bit not masking");
   a_max_mask: assert property (user_irq_block == (cpu_prio[3] || cpu_prio[2:0] == 3'h7))
      else $error("mask level wrong");
   a_rep_view: assert property (cpu_status_reg[4] == repeat_active)
      else $error("repeat bit wrong");
   a_loop_view: assert property (cpu_status_reg[9] == hw_loop_active)
      else $error("loop bit wrong");
   a_either_or: assert property (cpu_status_reg[11] == (cpu_status_reg[15] | cpu_status_reg[14]))
      else $error("combined overflow wrong");
   a_sticky_rise: assert property ($rose(cpu_status_reg[13]) |-> $past(acc_events.sat_a))
      else $error("sticky set without event");
   a_sab_clear: assert property (sw_st && !reg_wdata[10] && !acc_events.sat_a && !acc_events.sat_b |=> !cpu_status_reg[13] && !cpu_status_reg[12])
      else $error("sticky pair not cleared");
   a_neg_load: assert property (alu_flags.upd_n |=> cpu_status_reg[3] == $past(alu_flags.n))
      else $error("negative flag not loaded");
   a_carry_load: assert property (alu_flags.upd_c |=> cpu_status_reg[0] == $past(alu_flags.c))
      else $error("carry flag not loaded");
   a_zero_hold: assert property (zero_set ##1 zero_quiet |=> cpu_status_reg[1])
      else $error("zero flag lost");
   a_top_ro: assert property ($changed(cpu_prio[3]) |-> $past(prio_top_set) || $past(prio_top_clr))
      else $error("top bit changed by software");
endmodule
bind csf_top csf_top_asserts u_chk (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .alu_flags,
   .acc_events, .repeat_active, .hw_loop_active, .prio_top_set, .prio_top_clr, .cpu_status_reg,
   .cpu_prio, .user_irq_block);
`default_nettype wire

// file: tb/test_csf_top.sv
// testbench for the status flag register
`timescale 1ns/1ps
`default_nettype none
module test_csf_top;
   import csf_pkg::*;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [15:0] reg_rdata, st;
   csf_alu_t alu_req = '0;
   csf_alu_t alu_flags;
   csf_acc_t acc_req = '0;
   csf_acc_t acc_events;
   logic [2:0] ctl_req = 3'h0;
   logic [4:0] lvl_req = 5'h00;
   logic repeat_active, hw_loop_active, prio_top_set, prio_top_clr, prio_load, blk;
   logic [2:0] prio_load_val;
   logic [3:0] prio;
   int errors = 0;
   int cmp_count = 0;
   csf_top dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alu_flags,
      .acc_events, .repeat_active, .hw_loop_active, .prio_top_set, .prio_top_clr, .prio_load,
      .prio_load_val, .cpu_status_reg(st), .cpu_prio(prio), .user_irq_block(blk));
   csf_core_model core (.mclk, .alu_req, .acc_req, .ctl_req, .lvl_req, .alu_flags, .acc_events,
      .prio_top_set, .prio_top_clr, .prio_load, .repeat_active, .hw_loop_active, .prio_load_val);
   initial
   begin
      forever #20 mclk = ~mclk;
   end
   // ******************************
   // access tasks
   // ******************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge mclk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1;
      chk(reg_rdata & m, e);
   endtask
   task automatic ev(input csf_alu_t a, input csf_acc_t c, input logic [2:0] k);
      @(posedge mclk);
      alu_req <= a;
      acc_req <= c;
      ctl_req <= k;
      @(posedge mclk);
      alu_req <= '0;
      acc_req <= '0;
      ctl_req <= 3'h0;
      @(posedge mclk);
      #1;
   endtask
   task automatic finish_test;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      #2000000;
      errors++;
      finish_test();
   end
   // ******************************
   // main sequence
   // ******************************
   initial
   begin
      repeat (16) @(posedge mclk);
      reset <= 1'h0;
      rd(CSF_ADDR_STATUS, 16'hFFFF, 16'h0000);
      rd(CSF_ADDR_IRQCTL, 16'hFFFF, 16'h0000);
      rd(2'h3, 16'hFFFF, 16'h0000);
      wr(CSF_ADDR_STATUS, 16'h00E0);
      chk({8'h00, prio, 3'h0, blk}, 16'h0071);
      rd(CSF_ADDR_STATUS, 16'h00E0, 16'h00E0);
      wr(CSF_ADDR_STATUS, 16'h0060);
      chk({8'h00, prio, 3'h0, blk}, 16'h0030);
      ev('0, '0, 3'h4);
      chk({8'h00, prio, 3'h0, blk}, 16'h00B1);
      wr(CSF_ADDR_CORE, 16'h0000);
      rd(CSF_ADDR_CORE, 16'h0008, 16'h0008);
      ev('0, '0, 3'h2);
      chk({8'h00, prio, 3'h0, blk}, 16'h0030);
      wr(CSF_ADDR_IRQCTL, 16'h8000);
      rd(CSF_ADDR_IRQCTL, 16'h8000, 16'h8000);
      wr(CSF_ADDR_STATUS, 16'h00A0);
      chk(st & 16'h00E0, 16'h0060);
      wr(CSF_ADDR_IRQCTL, 16'h0000);
      wr(CSF_ADDR_STATUS, 16'h34A0);
      chk(st & 16'h34E0, 16'h00A0);
      ev('0, 4'h2, 3'h0);
      chk(st & 16'h3400, 16'h2400);
      wr(CSF_ADDR_STATUS, 16'h0400);
      chk(st & 16'h3400, 16'h0000);
      ev('0, 4'h3, 3'h0);
      wr(CSF_ADDR_STATUS, 16'h3000);
      chk(st & 16'h3400, 16'h0000);
      @(posedge mclk);
      lvl_req <= 5'h1A;
      ev('0, '0, 3'h1);
      chk(st & 16'h02F0, 16'h0250);
      wr(CSF_ADDR_STATUS, 16'h0000);
      chk(st & 16'h02F0, 16'h0210);
      @(posedge mclk);
      lvl_req <= 5'h00;
      ev(10'h3FF, '0, 3'h0);
      chk(st & 16'h010F, 16'h010F);
      ev(10'h28A, '0, 3'h0);
      chk(st & 16'h010F, 16'h0002);
      ev(10'h020, '0, 3'h0);
      chk(st & 16'h010F, 16'h0000);
      ev('0, 4'h8, 3'h0);
      chk(st & 16'hC800, 16'h8800);
      finish_test();
   end
endmodule
`default_nettype wire
